// [hcc_cmd_handler.sv]
/*
 * host control command handler: takes 9-byte direct-mode frames,
 * runs the program-control opcodes and the position event request,
 * forwards every other command (stores it in download mode), and sends 9-byte replies.
 * assumes rx/tx bytes come from logic on clk_sys_i (no synchroniser)
 * and that the motion core pulses move_start_i and pos_reached_i.
 */
`timescale 1ns/1ps
module hcc_cmd_handler (
	input  wire logic        clk_sys_i,         // system clock, 10 MHz
	input  wire logic        rst_i,             // async reset, high
	input  wire logic [7:0]  rx_data_i,         // command byte
	input  wire logic        rx_valid_i,        // command byte valid
	output logic             rx_ready_o,        // handler takes bytes
	output logic      [7:0]  tx_data_o,         // reply byte
	output logic             tx_valid_o,        // reply byte valid
	input  wire logic        tx_ready_i,        // link takes reply byte
	input  wire logic        move_start_i,      // move_to_position_cmd began
	input  wire logic        pos_reached_i,     // target position reached
	input  wire logic [7:0]  prog_pc_i,         // program counter
	input  wire logic [31:0] prog_acc_i,        // accumulator
	input  wire logic [31:0] prog_index_i,      // index register
	input  wire logic        prog_wait_i,       // program wait flag
	output logic             prog_run_o,        // program may execute
	output logic             prog_step_o,       // run one instruction
	output logic             prog_clear_o,      // clear pc/sp/acc/x/flags
	output logic             prog_load_o,       // load pc from prog_addr_o
	output logic      [7:0]  prog_addr_o,       // start address
	output logic             download_o,        // download mode active
	output logic             cmd_valid_o,       // forwarded command strobe
	output logic      [7:0]  cmd_op_o,          // forwarded opcode
	output logic      [7:0]  cmd_type_o,        // forwarded type
	output logic      [7:0]  cmd_bank_o,        // forwarded motor/bank
	output logic      [31:0] cmd_value_o,       // forwarded value
	output logic             factory_restore_o, // restore defaults pulse
	output logic             soft_reset_o       // restart device pulse
);

	// ----------------------------------------
	// state and registers
	// ----------------------------------------
	hcc_pkg::hcc_state_t st_q, st_d;   // main sequencer
	hcc_pkg::hcc_kind_t  kind_q;       // reply kind chosen
	logic [3:0]          cnt_q;        // rx or tx byte index
	logic [71:0]         frame_q;      // received frame, first byte high
	logic [71:0]         sh_q;         // reply shift register
	logic [7:0]          status_q;     // reply status
	logic [31:0]         val_q;        // reply value
	logic                rdy_q;        // rx ready flop
	logic                txv_q;        // tx valid flop
	logic                run_q;        // program running
	logic                dl_q;         // download mode
	logic [7:0]          dl_ptr_q;     // download write pointer
	logic                arm_once_q;   // next move reports arrival
	logic                arm_all_q;    // every move reports arrival
	logic                watch_q;      // current move reports arrival
	logic                evt_pend_q;   // arrival reply owed
	logic [7:0]          mask_q;       // motor bit mask for replies
	logic                step_q;       // step pulse
	logic                clear_q;      // clear pulse
	logic                load_q;       // pc load pulse
	logic [7:0]          addr_q;       // pc load address
	logic                fwd_q;        // forward pulse
	logic                fact_q;       // factory restore pulse
	logic                swr_q;        // software reset pulse
	logic [55:0]         mem_rd;       // program word read back

	// ----------------------------------------
	// frame fields
	// ----------------------------------------
	wire [7:0]  f_addr  = frame_q[71:64]; // target address
	wire [7:0]  f_op    = frame_q[63:56]; // opcode
	wire [7:0]  f_type  = frame_q[55:48]; // type
	wire [31:0] f_value = frame_q[39:8];  // value, msb first
	wire [7:0]  f_csum  = frame_q[7:0];   // checksum
	// motor/bank byte frame_q[47:40] is not used by control opcodes

	// ----------------------------------------
	// checksum adders, one stage per byte
	// ----------------------------------------
	logic [63:0] body_w;        // reply bytes before checksum
	logic [7:0]  rx_sum [0:8];  // running sum of command bytes
	logic [7:0]  tx_sum [0:8];  // running sum of reply bytes
	assign rx_sum[0] = 8'h00;
	assign tx_sum[0] = 8'h00;
	genvar gi;
	generate
		for (gi = 0; gi < 8; gi++) begin : g_sum
			// modulo-256 sums wrap on purpose
			assign rx_sum[gi+1] = rx_sum[gi] + frame_q[71-8*gi -: 8];
			assign tx_sum[gi+1] = tx_sum[gi] + body_w[63-8*gi -: 8];
		end
	endgenerate

	// ----------------------------------------
	// command decode
	// ----------------------------------------
	wire acc_w = rx_valid_i & rdy_q;                 // byte taken
	// wrong address or checksum: frame dropped silently
	wire ok_w = (f_addr == hcc_pkg::ADDR_MODULE) & (rx_sum[8] == f_csum);
	// control set only arrives here from the host link
	wire is_ctl = ((f_op >= hcc_pkg::OP_STOP) & (f_op <= hcc_pkg::OP_POS_EVT))
		| (f_op == hcc_pkg::OP_SW_RESET);
	wire op_run  = f_op == hcc_pkg::OP_RUN;
	wire op_evt  = f_op == hcc_pkg::OP_POS_EVT;
	wire op_stat = f_op == hcc_pkg::OP_STATUS;
	wire op_ver  = f_op == hcc_pkg::OP_VERSION;
	wire op_kill = (f_op == hcc_pkg::OP_FACTORY) | (f_op == hcc_pkg::OP_SW_RESET);
	wire bad_type = ((op_run | op_evt | op_ver) & (f_type > 8'h01))
		| (op_stat & (f_type > 8'h03));
	wire bad_val  = op_kill & (f_value != hcc_pkg::MAGIC_VALUE);
	wire ctl_go   = (st_q == hcc_pkg::S_EXEC) & ok_w & is_ctl & ~bad_type & ~bad_val;
	wire plain_w  = (st_q == hcc_pkg::S_EXEC) & ok_w & ~is_ctl; // non-control
	wire store_w  = plain_w & dl_q;
	wire fwd_w    = plain_w & ~dl_q;
	wire go_op    = ctl_go;                                      // alias for tests below
	wire do_stop  = go_op & (f_op == hcc_pkg::OP_STOP);
	wire do_run   = go_op & op_run;
	wire do_step  = go_op & (f_op == hcc_pkg::OP_STEP);
	wire do_rst   = go_op & (f_op == hcc_pkg::OP_RESET);
	wire do_dlon  = go_op & (f_op == hcc_pkg::OP_DL_ENTER);
	wire do_dloff = go_op & (f_op == hcc_pkg::OP_DL_EXIT);
	wire do_evt   = go_op & op_evt;
	wire do_fact  = go_op & (f_op == hcc_pkg::OP_FACTORY);
	wire do_swr   = go_op & (f_op == hcc_pkg::OP_SW_RESET);

	// ----------------------------------------
	// reply selection
	// ----------------------------------------
	// forwarded commands are answered by the unit that executes them
	wire silent_w = ~ok_w | (~is_ctl & ~dl_q) | (op_kill & ~bad_val);
	wire [7:0] mode_w = dl_q ? hcc_pkg::MODE_DOWNLOAD
		: (run_q ? hcc_pkg::MODE_RUN : hcc_pkg::MODE_IDLE);
	wire [15:0] where_w = (f_type == 8'h00) ? {8'h00, dl_ptr_q} : {8'h00, prog_pc_i};
	wire [31:0] stat_w = (f_type[1] == 1'b0) ? {mode_w, 7'h00, prog_wait_i, where_w}
		: (f_type[0] ? prog_index_i : prog_acc_i);
	wire [31:0] rval_w = op_evt ? {24'h00_0000, f_value[7:0]}
		: op_stat ? stat_w
		: op_ver ? hcc_pkg::VERSION_BIN : 32'h0000_0000;
	wire [7:0] rstat_w = bad_type ? hcc_pkg::ST_WRONG_TYPE
		: (bad_val ? hcc_pkg::ST_WRONG_VALUE : hcc_pkg::ST_OK);
	wire hcc_pkg::hcc_kind_t rkind_w = silent_w ? hcc_pkg::K_NONE
		: (f_op == hcc_pkg::OP_MEM_READ) & is_ctl ? hcc_pkg::K_MEM
		: op_ver & (f_type == 8'h00) ? hcc_pkg::K_STR
		: hcc_pkg::K_STD;

	// assembled reply body, chosen by kind
	assign body_w = (kind_q == hcc_pkg::K_MEM) ? {hcc_pkg::ADDR_HOST, mem_rd}
		: (kind_q == hcc_pkg::K_STR) ? hcc_pkg::VERSION_STR
		: (kind_q == hcc_pkg::K_EVT) ? {hcc_pkg::ADDR_HOST, hcc_pkg::ADDR_MODULE,
			hcc_pkg::ST_POS_REACHED, hcc_pkg::OP_POS_EVT, 24'h00_0000, mask_q}
		: {hcc_pkg::ADDR_HOST, hcc_pkg::ADDR_MODULE, status_q, f_op, val_q};

	// ----------------------------------------
	// sequencer
	// ----------------------------------------
	wire tx_fire  = txv_q & tx_ready_i;                          // byte sent
	// arrival reply waits for a quiet link, never cuts into a frame
	wire take_evt = (st_q == hcc_pkg::S_IDLE) & evt_pend_q
		& (cnt_q == hcc_pkg::CNT_RST) & ~acc_w;
	wire rx_last  = acc_w & (cnt_q == hcc_pkg::FRAME_LAST);

	// next state
	always_comb begin
		case (st_q)
			hcc_pkg::S_IDLE: begin
				if (rx_last) begin
					st_d = hcc_pkg::S_EXEC;
				end else if (take_evt) begin
					st_d = hcc_pkg::S_BUILD;
				end else begin
					st_d = hcc_pkg::S_IDLE;
				end
			end
			hcc_pkg::S_EXEC: begin
				st_d = (rkind_w == hcc_pkg::K_NONE) ? hcc_pkg::S_IDLE : hcc_pkg::S_BUILD;
			end
			hcc_pkg::S_BUILD: begin
				st_d = hcc_pkg::S_SEND;
			end
			hcc_pkg::S_SEND: begin
				st_d = (tx_fire & (cnt_q == hcc_pkg::FRAME_LAST)) ? hcc_pkg::S_IDLE
					: hcc_pkg::S_SEND;
			end
			default: begin
				st_d = hcc_pkg::S_IDLE;
			end
		endcase
	end

	// state, byte counter, rx handshake
	always_ff @(posedge clk_sys_i or posedge rst_i) begin
		if (rst_i) begin
			st_q  <= hcc_pkg::S_IDLE;
			cnt_q <= hcc_pkg::CNT_RST;
			rdy_q <= 1'b0;
		end else begin
			st_q  <= st_d;
			rdy_q <= (st_d == hcc_pkg::S_IDLE); // stall the source while busy
			if (acc_w | tx_fire) begin
				cnt_q <= (cnt_q == hcc_pkg::FRAME_LAST) ? hcc_pkg::CNT_RST : cnt_q + 4'h1;
			end
		end
	end

	// frame capture, first byte ends up on top
	always_ff @(posedge clk_sys_i or posedge rst_i) begin
		if (rst_i) begin
			frame_q <= '0;
		end else if (acc_w) begin
			frame_q <= {frame_q[63:0], rx_data_i};
		end
	end

	// ----------------------------------------
	// reply register and shifter
	// ----------------------------------------
	always_ff @(posedge clk_sys_i or posedge rst_i) begin
		if (rst_i) begin
			kind_q   <= hcc_pkg::K_NONE;
			status_q <= hcc_pkg::BYTE_RST;
			val_q    <= '0;
			sh_q     <= '0;
			txv_q    <= 1'b0;
		end else begin
			if (st_q == hcc_pkg::S_EXEC) begin
				kind_q   <= rkind_w;
				status_q <= rstat_w;
				val_q    <= rval_w;
			end else if (take_evt) begin
				kind_q <= hcc_pkg::K_EVT;
			end
			if (st_q == hcc_pkg::S_BUILD) begin
				sh_q  <= {body_w, tx_sum[8]};
				txv_q <= 1'b1;
			end else if (tx_fire) begin
				sh_q  <= {sh_q[63:0], hcc_pkg::BYTE_RST};
				txv_q <= (cnt_q != hcc_pkg::FRAME_LAST);
			end
		end
	end

	// ----------------------------------------
	// program control state
	// ----------------------------------------
	// stop and reset both win over run if ever seen together
	always_ff @(posedge clk_sys_i or posedge rst_i) begin
		if (rst_i) begin
			run_q    <= 1'b0;
			dl_q     <= 1'b0;
			dl_ptr_q <= hcc_pkg::BYTE_RST;
			addr_q   <= hcc_pkg::BYTE_RST;
		end else begin
			if (do_stop | do_rst) begin
				run_q <= 1'b0;
			end else if (do_run) begin
				run_q <= 1'b1;
			end
			if (do_dlon) begin
				dl_q     <= 1'b1;
				dl_ptr_q <= f_value[7:0];
			end else if (do_dloff) begin
				dl_q <= 1'b0;
			end else if (store_w) begin
				dl_ptr_q <= dl_ptr_q + 8'h01;
			end
			if (do_run & (f_type == 8'h01)) begin
				addr_q <= f_value[7:0];
			end
		end
	end

	// one-cycle pulses to the program core and the system
	always_ff @(posedge clk_sys_i or posedge rst_i) begin
		if (rst_i) begin
			step_q  <= 1'b0;
			clear_q <= 1'b0;
			load_q  <= 1'b0;
			fwd_q   <= 1'b0;
			fact_q  <= 1'b0;
			swr_q   <= 1'b0;
		end else begin
			step_q  <= do_step;
			clear_q <= do_rst;
			load_q  <= do_run & (f_type == 8'h01);
			fwd_q   <= fwd_w;
			fact_q  <= do_fact;
			swr_q   <= do_swr;
		end
	end

	// forwarded command fields, held until the next forward
	always_ff @(posedge clk_sys_i or posedge rst_i) begin
		if (rst_i) begin
			cmd_op_o    <= hcc_pkg::BYTE_RST;
			cmd_type_o  <= hcc_pkg::BYTE_RST;
			cmd_bank_o  <= hcc_pkg::BYTE_RST;
			cmd_value_o <= '0;
		end else if (fwd_w) begin
			cmd_op_o    <= f_op;
			cmd_type_o  <= f_type;
			cmd_bank_o  <= frame_q[47:40];
			cmd_value_o <= f_value;
		end
	end

	// ----------------------------------------
	// position reached event
	// ----------------------------------------
	// arrival while owed: set wins over the clear of a reply being taken
	always_ff @(posedge clk_sys_i or posedge rst_i) begin
		if (rst_i) begin
			arm_once_q <= 1'b0;
			arm_all_q  <= 1'b0;
			watch_q    <= 1'b0;
			evt_pend_q <= 1'b0;
			mask_q     <= hcc_pkg::BYTE_RST;
		end else begin
			if (do_evt) begin
				arm_once_q <= (f_type == 8'h00);
				arm_all_q  <= (f_type == 8'h01);
				mask_q     <= f_value[7:0];
			end else if (move_start_i) begin
				arm_once_q <= 1'b0;
			end
			if (move_start_i) begin
				watch_q <= arm_once_q | arm_all_q;
			end else if (pos_reached_i) begin
				watch_q <= 1'b0;
			end
			evt_pend_q <= (pos_reached_i & watch_q) | (evt_pend_q & ~take_evt);
		end
	end

	// ----------------------------------------
	// program memory
	// ----------------------------------------
	hcc_prog_mem u_mem (
		.clk_sys_i (clk_sys_i),
		.wr_en_i   (store_w),
		.wr_addr_i (dl_ptr_q),
		.wr_data_i (frame_q[63:8]),
		.rd_addr_i (f_value[7:0]),
		.rd_data_o (mem_rd)
	);

	// ----------------------------------------
	// outputs, all from flops
	// ----------------------------------------
	assign rx_ready_o        = rdy_q;
	assign tx_data_o         = sh_q[71:64];
	assign tx_valid_o        = txv_q;
	assign prog_run_o        = run_q;
	assign prog_step_o       = step_q;
	assign prog_clear_o      = clear_q;
	assign prog_load_o       = load_q;
	assign prog_addr_o       = addr_q;
	assign download_o        = dl_q;
	assign cmd_valid_o       = fwd_q;
	assign factory_restore_o = fact_q;
	assign soft_reset_o      = swr_q;

endmodule

// [hcc_cmd_handler_checker.sv]
/*
 * concurrent checks on the command handler's ports.
 * assumes the byte timing of the hand-over: outputs of a frame show
 * two edges after its checksum byte is taken, the reply on the third.
 */
`timescale 1ns/1ps
module hcc_cmd_handler_checker (
	input wire logic       clk_sys_i,         // system clock
	input wire logic       rst_i,             // async reset
	input wire logic [7:0] rx_data_i,         // command byte
	input wire logic       rx_valid_i,        // byte offered
	input wire logic       rx_ready_o,        // byte taken
	input wire logic [7:0] tx_data_o,         // reply byte
	input wire logic       tx_valid_o,        // reply offered
	input wire logic       cmd_valid_o,       // forward strobe
	input wire logic       prog_run_o,        // program runs
	input wire logic       prog_step_o,       // step pulse
	input wire logic       prog_clear_o,      // clear pulse
	input wire logic       prog_load_o,       // load pulse
	input wire logic [7:0] prog_addr_o,       // start address
	input wire logic       download_o,        // download mode
	input wire logic       factory_restore_o, // restore pulse
	input wire logic       soft_reset_o       // restart pulse
);
	// ----------------------------------------
	// frame tracker
	// ----------------------------------------
	logic [3:0]  n_q; // bytes of frame so far
	logic [63:0] f_q; // bytes 0..7 shifted in
	logic [7:0]  s_q; // running sum
	wire         tk   = rx_valid_i && rx_ready_o;
	wire         last = tk && (n_q == 4'h8);
	wire         fin  = last && (s_q == rx_data_i) && (f_q[63:56] == hcc_pkg::ADDR_MODULE);
	wire  [7:0]  op   = f_q[55:48];
	wire         mg   = (f_q[31:0] == hcc_pkg::MAGIC_VALUE);
	// counts whole frames only; a partial frame holds, as in the handler
	always_ff @(posedge clk_sys_i or posedge rst_i) begin
		if (rst_i) begin
			n_q <= 4'h0;
			f_q <= 64'h0000_0000_0000_0000;
			s_q <= 8'h00;
		end else if (tk) begin
			n_q <= last ? 4'h0 : n_q + 4'h1;
			f_q <= {f_q[55:0], rx_data_i};
			s_q <= last ? 8'h00 : s_q + rx_data_i;
		end
	end
	default clocking @(posedge clk_sys_i); endclocking
	default disable iff (rst_i);
	// ----------------------------------------
	// properties
	// ----------------------------------------
	property p_stop; fin && op == hcc_pkg::OP_STOP |-> ##2 !prog_run_o; endproperty
	a_stop: assert property (p_stop) else $error("stop left program running");
	property p_run; fin && op == hcc_pkg::OP_RUN |-> ##2 prog_run_o; endproperty
	a_run: assert property (p_run) else $error("run did not start program");
	property p_load; fin && op == hcc_pkg::OP_RUN && f_q[47:40] == 8'h01 |-> ##2 prog_load_o && prog_addr_o == $past(f_q[7:0], 2);
	endproperty
	a_load: assert property (p_load) else $error("run from address wrong");
	property p_step; fin && op == hcc_pkg::OP_STEP |-> ##2 prog_step_o ##1 !prog_step_o; endproperty
	a_step: assert property (p_step) else $error("step pulse wrong");
	property p_clear; fin && op == hcc_pkg::OP_RESET |-> ##2 prog_clear_o && !prog_run_o; endproperty
	a_clear: assert property (p_clear) else $error("program reset wrong");
	property p_dl_on; fin && op == hcc_pkg::OP_DL_ENTER |-> ##2 download_o; endproperty
	a_dl_on: assert property (p_dl_on) else $error("download not entered");
	property p_dl_off; fin && op == hcc_pkg::OP_DL_EXIT |-> ##2 !download_o; endproperty
	a_dl_off: assert property (p_dl_off) else $error("download not left");
	property p_evt_now; fin && op == hcc_pkg::OP_POS_EVT |-> ##3 tx_valid_o && tx_data_o == hcc_pkg::ADDR_HOST;
	endproperty
	a_evt_now: assert property (p_evt_now) else $error("event request not answered");
	property p_factory; fin && op == hcc_pkg::OP_FACTORY && mg |-> ##2 factory_restore_o ##1 !tx_valid_o [*6];
	endproperty
	a_factory: assert property (p_factory) else $error("factory restore wrong");
	property p_swrst; fin && op == hcc_pkg::OP_SW_RESET && mg |-> ##2 soft_reset_o; endproperty
	a_swrst: assert property (p_swrst) else $error("software reset missing");
	property p_bad; last && !fin |=> !cmd_valid_o [*4]; endproperty
	a_bad: assert property (p_bad) else $error("bad frame acted on");
endmodule
bind hcc_cmd_handler hcc_cmd_handler_checker i_chk (.*);

// [hcc_cmd_handler_test.sv]
/*
 * self-checking bench for the command handler: table of query and
 * control frames, then event, download, program, refusal and reset cases.
 * assumes the host model answers every reply byte and sends frames whole.
 */
`timescale 1ns/1ps
module hcc_cmd_handler_test;
	logic        clk_sys_i = 0, rst_i = 1, move_start_i = 0, pos_reached_i = 0, prog_wait_i = 1;
	logic        rx_valid_i, rx_ready_o, tx_valid_o, tx_ready_i, prog_run_o, prog_step_o, prog_clear_o;
	logic        prog_load_o, download_o, cmd_valid_o, factory_restore_o, soft_reset_o;
	logic [7:0]  rx_data_i, tx_data_o, prog_addr_o, cmd_op_o, cmd_type_o, cmd_bank_o, prog_pc_i = 8'h5A;
	logic [31:0] cmd_value_o, prog_acc_i = 32'h1234_5678, prog_index_i = 32'h0BAD_F00D;
	int          n_mismatch = 0, num_checks = 0, cyc = 0;
	typedef struct { logic [7:0] op, ty; logic [31:0] val; logic [63:0] e; } hcc_row_t;
	hcc_row_t rows[7] = '{
		'{8'h8A, 8'h01, 32'h1, 64'h0201_648A_0000_0001},
		'{8'h87, 8'h02, 32'h0, {32'h0201_6487, 32'h1234_5678}},
		'{8'h87, 8'h03, 32'h0, {32'h0201_6487, 32'h0BAD_F00D}},
		'{8'h87, 8'h01, 32'h0, 64'h0201_6487_0001_005A},
		'{8'h88, 8'h01, 32'h0, {32'h0201_6488, hcc_pkg::VERSION_BIN}},
		'{8'h89, 8'h00, 32'h5, 64'h0201_0489_0000_0000},
		'{8'h88, 8'h00, 32'h0, hcc_pkg::VERSION_STR}};
	always #50 clk_sys_i = ~clk_sys_i;
	hcc_cmd_handler i_dut (.*);
	hcc_host_model i_host (.clk_sys_i(clk_sys_i), .rx_data_o(rx_data_i), .rx_valid_o(rx_valid_i),
		.rx_ready_i(rx_ready_o), .tx_data_i(tx_data_o), .tx_valid_i(tx_valid_o), .tx_ready_o(tx_ready_i));
	// ----------------------------------------
	// compare, reply and stimulus helpers
	// ----------------------------------------
	task chk(input logic [63:0] g, e);
		num_checks++;
		if (g !== e) begin
			n_mismatch++;
			$display("[FAIL] %0t got %h expected %h", $time, g, e);
		end
	endtask
	// reply bytes 0..7 as given, checksum worked out here
	task rep(input logic [63:0] e);
		logic [7:0] s;
		s = 8'h00;
		for (int i = 0; i < 400 && i_host.rq.size() < 9; i++) @(posedge clk_sys_i);
		chk(i_host.rq.size(), 9);
		if (i_host.rq.size() < 9) return;
		for (int i = 0; i < 8; i++) begin
			s += e[63-8*i -: 8];
			chk(i_host.rq.pop_front(), e[63-8*i -: 8]);
		end
		chk(i_host.rq.pop_front(), s);
	endtask
	// no reply may come within a generous gap
	task quiet;
		repeat (40) @(posedge clk_sys_i);
		chk(i_host.rq.size(), 0);
	endtask
	// one move start then arrival, pulses a cycle long
	task mv;
		move_start_i <= 1'b1;
		@(posedge clk_sys_i) move_start_i <= 1'b0;
		repeat (4) @(posedge clk_sys_i);
		pos_reached_i <= 1'b1;
		@(posedge clk_sys_i) pos_reached_i <= 1'b0;
	endtask
	task reset_dut;
		rst_i <= 1'b1;
		repeat (16) @(posedge clk_sys_i);
		chk({rx_ready_o, tx_valid_o, prog_run_o, download_o, cmd_valid_o}, 0);
		rst_i <= 1'b0;
		repeat (2) @(posedge clk_sys_i);
		$display("test reset done");
	endtask
	task wrap_up;
		$display("checks %0d mismatches %0d", num_checks, n_mismatch);
		if (n_mismatch == 0 && num_checks > 0) $display("== PASSED ==");
		else $display("== FAILED ==");
		$finish;
	endtask
	// hang guard well above the length of the run
	always @(posedge clk_sys_i) begin
		cyc++;
		if (cyc == 30000) begin
			n_mismatch++;
			wrap_up();
		end
	end
	// ----------------------------------------
	// main sequence
	// ----------------------------------------
	initial begin
		reset_dut();
		foreach (rows[k]) begin
			i_host.slow = (k == 6);
			i_host.send(rows[k].op, rows[k].ty, rows[k].val, 8'h00);
			rep(rows[k].e);
		end
		i_host.slow = 0;
		$display("test table done");
		repeat (2) mv();
		rep(64'h0201_808A_0000_0001);
		rep(64'h0201_808A_0000_0001);
		i_host.send(8'h84, 8'h00, 32'h3, 8'h00);
		rep(64'h0201_6484_0000_0000);
		chk(download_o, 1);
		i_host.send(8'h04, 8'h01, 32'h77, 8'h00);
		rep(64'h0201_6404_0000_0000);
		i_host.send(8'h87, 8'h00, 32'h0, 8'h00);
		rep(64'h0201_6487_0201_0004);
		i_host.send(8'h85, 8'h00, 32'h0, 8'h00);
		rep(64'h0201_6485_0000_0000);
		i_host.send(8'h86, 8'h00, 32'h3, 8'h00);
		rep(64'h0204_0100_0000_0077);
		i_host.send(8'h04, 8'h01, 32'h77, 8'h00);
		quiet();
		chk({cmd_op_o, cmd_type_o, cmd_bank_o, cmd_value_o}, 56'h04_0100_0000_0077);
		$display("test download done");
		i_host.send(8'h81, 8'h01, 32'h5, 8'h00);
		rep(64'h0201_6481_0000_0000);
		chk({prog_run_o, prog_addr_o}, 9'h105);
		foreach (rows[k]) if (k < 4) begin
			i_host.send(8'h83 - 8'(k), 8'h00, 32'h0, 8'h00);
			rep({16'h0201, 8'h64, 8'h83 - 8'(k), 32'h0});
		end
		chk(prog_run_o, 0);
		i_host.send(8'h80, 8'h00, 32'h0, 8'h01);
		quiet();
		i_host.send(8'h89, 8'h00, 32'h0000_04D2, 8'h00);
		quiet();
		i_host.send(8'hFF, 8'h00, 32'h0000_04D2, 8'h00);
		quiet();
		$display("test control done");
		reset_dut();
		i_host.send(8'h8A, 8'h00, 32'h1, 8'h00);
		rep(64'h0201_648A_0000_0001);
		mv();
		rep(64'h0201_808A_0000_0001);
		mv();
		quiet();
		$display("test event done");
		wrap_up();
	end
endmodule

// [hcc_host_model.sv]
/*
 * host side of the command link: sends 9-byte command frames and
 * collects every reply byte into a queue for the bench to inspect.
 * assumes it shares clk_sys_i with the handler and is driven by tasks.
 */
`timescale 1ns/1ps
module hcc_host_model (
	input  wire logic       clk_sys_i,  // system clock
	output logic      [7:0] rx_data_o,  // command byte to handler
	output logic            rx_valid_o, // command byte offered
	input  wire logic       rx_ready_i, // handler takes byte
	input  wire logic [7:0] tx_data_i,  // reply byte
	input  wire logic       tx_valid_i, // reply byte offered
	output logic            tx_ready_o  // host takes reply byte
);
	logic [7:0] rq[$];  // reply bytes in arrival order
	bit         slow;   // stall the reply link every other cycle
	initial begin
		rx_data_o  = 8'h00;
		rx_valid_o = 1'b0;
		tx_ready_o = 1'b0;
		slow       = 1'b0;
	end
	// ----------------------------------------
	// reply side: take bytes, optionally stall
	// ----------------------------------------
	always @(posedge clk_sys_i) begin
		if (tx_valid_i && tx_ready_o) begin
			rq.push_back(tx_data_i);
		end
		tx_ready_o <= slow ? ~tx_ready_o : 1'b1;
	end
	// ----------------------------------------
	// command side: one frame, bad adds a checksum error
	// ----------------------------------------
	task automatic send(input logic [7:0] op, ty, input logic [31:0] val, input logic [7:0] bad);
		logic [7:0] f[9];
		f = '{8'h01, op, ty, 8'h00, val[31:24], val[23:16], val[15:8], val[7:0], bad};
		for (int i = 0; i < 8; i++) f[8] += f[i];
		for (int i = 0; i < 9; i++) begin
			rx_data_o  <= f[i];
			rx_valid_o <= 1'b1;
			do @(posedge clk_sys_i); while (rx_ready_i !== 1'b1);
		end
		// released line shows the inverse, not a stale byte
		rx_valid_o <= 1'b0;
		rx_data_o  <= ~f[8];
	endtask
endmodule

// [hcc_pkg.sv]
/*
 * shared constants and types for the host control command handler:
 * opcodes, reply codes, frame layout, reset values and state encodings.
 * assumes a 9-byte command frame and a 9-byte reply frame on a byte link.
 */
package hcc_pkg;

	// ----------------------------------------
	// opcodes of the control set
	// ----------------------------------------
	localparam logic [7:0] OP_STOP     = 8'h80; // halt program
	localparam logic [7:0] OP_RUN      = 8'h81; // run / resume
	localparam logic [7:0] OP_STEP     = 8'h82; // single step
	localparam logic [7:0] OP_RESET    = 8'h83; // program reset
	localparam logic [7:0] OP_DL_ENTER = 8'h84; // download on
	localparam logic [7:0] OP_DL_EXIT  = 8'h85; // download off
	localparam logic [7:0] OP_MEM_READ = 8'h86; // memory readback
	localparam logic [7:0] OP_STATUS   = 8'h87; // status query
	localparam logic [7:0] OP_VERSION  = 8'h88; // version query
	localparam logic [7:0] OP_FACTORY  = 8'h89; // factory restore
	localparam logic [7:0] OP_POS_EVT  = 8'h8A; // position event request
	localparam logic [7:0] OP_SW_RESET = 8'hFF; // software restart

	// ----------------------------------------
	// addresses, status codes, magic value
	// ----------------------------------------
	localparam logic [7:0]  ADDR_MODULE    = 8'h01;         // our address
	localparam logic [7:0]  ADDR_HOST      = 8'h02;         // reply address
	localparam logic [7:0]  ST_OK          = 8'h64;         // 100, ok
	localparam logic [7:0]  ST_POS_REACHED = 8'h80;         // 128, arrival
	localparam logic [7:0]  ST_WRONG_TYPE  = 8'h03;         // bad type field
	localparam logic [7:0]  ST_WRONG_VALUE = 8'h04;         // bad value field
	localparam logic [31:0] MAGIC_VALUE    = 32'h0000_04D2; // 1234
	localparam logic [7:0]  MODE_IDLE      = 8'h00;         // program stopped
	localparam logic [7:0]  MODE_RUN       = 8'h01;         // program running
	localparam logic [7:0]  MODE_DOWNLOAD  = 8'h02;         // download active

	// version answers, values arbitrary
	localparam logic [31:0] VERSION_BIN = 32'h0000_0101;            // arbitrary
	localparam logic [63:0] VERSION_STR = 64'h3030_3030_5630_3130; // arbitrary

	// ----------------------------------------
	// frame layout and sizes
	// ----------------------------------------
	localparam logic [3:0] FRAME_LAST = 4'h8; // index of checksum byte
	localparam int         MEM_AW     = 8;    // program address width
	localparam int         MEM_DW     = 56;   // op,type,bank,value
	localparam logic [3:0] CNT_RST    = 4'h0; // byte counter after reset
	localparam logic [7:0] BYTE_RST   = 8'h00; // byte registers after reset

	// ----------------------------------------
	// state and reply kind encodings
	// ----------------------------------------
	typedef enum logic [1:0] {
		S_IDLE  = 2'b00, // collecting command bytes
		S_EXEC  = 2'b01, // decode and act
		S_BUILD = 2'b11, // assemble reply
		S_SEND  = 2'b10  // shift reply out
	} hcc_state_t;

	typedef enum logic [2:0] {
		K_NONE = 3'h0, // no reply
		K_STD  = 3'h1, // standard reply
		K_MEM  = 3'h2, // memory word reply
		K_STR  = 3'h3, // version text reply
		K_EVT  = 3'h4  // position reached reply
	} hcc_kind_t;

endpackage

// [hcc_prog_mem.sv]
/*
 * program memory of the command handler: one write port, one read
 * port whose data come out of a register one clock after the address.
 * assumes the caller holds the read address steady for that clock.
 */
`timescale 1ns/1ps
module hcc_prog_mem (
	input  wire logic                      clk_sys_i, // system clock
	input  wire logic                      wr_en_i,   // write strobe
	input  wire logic [hcc_pkg::MEM_AW-1:0] wr_addr_i, // write address
	input  wire logic [hcc_pkg::MEM_DW-1:0] wr_data_i, // write word
	input  wire logic [hcc_pkg::MEM_AW-1:0] rd_addr_i, // read address
	output logic      [hcc_pkg::MEM_DW-1:0] rd_data_o  // registered word
);

	// ----------------------------------------
	// storage
	// ----------------------------------------
	// no reset: contents are defined only once downloaded
	logic [hcc_pkg::MEM_DW-1:0] mem_q [0:(1<<hcc_pkg::MEM_AW)-1]; // words

	// write and registered read
	always_ff @(posedge clk_sys_i) begin
		if (wr_en_i) begin
			mem_q[wr_addr_i] <= wr_data_i;
		end
		rd_data_o <= mem_q[rd_addr_i];
	end

endmodule
